// File: rtl/rtw_guard_seq.sv
// guard pattern sequencer: per-cycle drive choice after one kind of modulation edge
`timescale 1ns/1ps
`default_nettype none
module rtw_guard_seq (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic start,
  input wire logic abort,
  input wire rtw_pkg::rtw_guard_cfg_t cfg,
  output logic active,
  output logic [1:0] drive
);
  logic act_r;
  logic [3:0] idx_r;
  logic [1:0] drive_r;
  wire logic [13:0] pat_w = cfg.pattern;
  wire logic [1:0] first_drive = pat_w[0] ? cfg.sel : rtw_pkg::DRV_NORMAL;
  wire logic [1:0] step_drive = pat_w[idx_r] ? cfg.sel : rtw_pkg::DRV_NORMAL;
  // idx_r is one ahead of the bit on show, so bit 13 still plays before the stop
  wire logic last_step = idx_r == 4'(rtw_pkg::GUARD_LEN);
  assign active = act_r;
  assign drive = drive_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      act_r <= 1'b0;
      idx_r <= 4'h0;
      drive_r <= rtw_pkg::DRV_NORMAL;
    end else if (en) begin
      if (start) begin
        // a new edge restarts even a half-played pattern
        act_r <= 1'b1;
        idx_r <= 4'h1;
        drive_r <= first_drive;
      end else if (act_r && !abort && !last_step) begin
        idx_r <= idx_r + 4'h1;
        drive_r <= step_drive;
      end else begin
        act_r <= 1'b0;
        drive_r <= rtw_pkg::DRV_NORMAL;
      end
    end
  end

  zero_pattern_a: assert property (@(posedge sys_clk) disable iff (rst || !en)
    $past(pat_w) == 14'h0 |-> drive_r == rtw_pkg::DRV_NORMAL)
    else $error("zero pattern did not give normal drive");
  drive_select_a: assert property (@(posedge sys_clk) disable iff (rst || !en)
    drive_r != rtw_pkg::DRV_NORMAL |-> drive_r == $past(cfg.sel))
    else $error("guard drive differs from selector");
  first_cycle_a: assert property (@(posedge sys_clk) disable iff (rst || !en)
    start |=> drive_r == $past(first_drive) && idx_r == 4'h1)
    else $error("pattern bit 0 not applied first");
  back_normal_a: assert property (@(posedge sys_clk) disable iff (rst || !en)
    act_r && last_step && !start |=> drive_r == rtw_pkg::DRV_NORMAL && !act_r)
    else $error("drive not normal after fourteen cycles");
  guard_play_c: cover property (@(posedge sys_clk) disable iff (rst || !en)
    start ##1 (act_r && drive_r != rtw_pkg::DRV_NORMAL));
endmodule : rtw_guard_seq
`default_nettype wire

// File: rtl/rtw_pkg.sv
// package: register map, field positions, codes and types of the reader transceive block
package rtw_pkg;
  localparam logic [7:0] ADDR_CMD = 8'h01;
  localparam logic [7:0] ADDR_OP_CTRL = 8'h02;
  localparam logic [7:0] ADDR_TX_WL = 8'h03;
  localparam logic [7:0] ADDR_RX_WL = 8'h04;
  localparam logic [7:0] ADDR_IRQ_MAIN = 8'h1A;
  localparam logic [7:0] ADDR_FIFO_STAT1 = 8'h1E;
  localparam logic [7:0] ADDR_FIFO_STAT2 = 8'h1F;
  localparam logic [7:0] ADDR_TXB1 = 8'h22;
  localparam logic [7:0] ADDR_TXB2 = 8'h23;
  localparam logic [7:0] ADDR_AUX_MOD = 8'h28;
  localparam logic [7:0] ADDR_WS_CFG = 8'h2E;
  localparam logic [7:0] ADDR_WS_CFG2 = 8'h2F;
  localparam logic [7:0] ADDR_OV_HI = 8'h30;
  localparam logic [7:0] ADDR_OV_LO = 8'h31;
  localparam logic [7:0] ADDR_UN_HI = 8'h32;
  localparam logic [7:0] ADDR_UN_LO = 8'h33;
  localparam logic [7:0] ADDR_SINK_FALL = 8'h34;
  localparam logic [7:0] ADDR_SINK_RISE = 8'h35;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h3F;
  localparam logic [7:0] CMD_STOP_ALL = 8'hC2;
  localparam logic [7:0] CMD_TRANSMIT = 8'hC4;
  localparam int OP_EN_BIT = 7;
  localparam int OP_RX_EN_BIT = 6;
  localparam int OP_TX_EN_BIT = 3;
  localparam int WS_EN_BIT = 3;
  localparam int GUARD_SEL_LSB = 6;
  localparam int IRQ_OSC = 7;
  localparam int IRQ_WL = 6;
  localparam int IRQ_RXE = 4;
  localparam int IRQ_TXE = 3;
  localparam int IRQ_COL = 2;
  localparam int IRQ_ERR = 1;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [7:0] TX_WL_RESET = 8'h10;
  localparam logic [7:0] RX_WL_RESET = 8'h40;
  localparam int GUARD_LEN = 14;
  localparam logic [1:0] DRV_DRIVER_RAIL = 2'h0;
  localparam logic [1:0] DRV_MOD_RAIL = 2'h1;
  localparam logic [1:0] DRV_STOP = 2'h2;
  localparam logic [1:0] DRV_NORMAL = 2'h3;
  typedef struct packed {
    logic [1:0] sel;
    logic [13:0] pattern;
  } rtw_guard_cfg_t;
  typedef enum logic [1:0] {ST_IDLE, ST_TX, ST_RX} rtw_state_t;
endpackage : rtw_pkg

// File: rtl/rtw_skid_buf.sv
// two-entry buffer with valid/ready on both sides, outputs from flops
`timescale 1ns/1ps
`default_nettype none
module rtw_skid_buf #(
  parameter int W = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  logic v0_r;
  logic v1_r;
  logic [W-1:0] d0_r;
  logic [W-1:0] d1_r;
  wire logic pop = v0_r && out_ready;
  wire logic push = in_valid && !v1_r;
  wire logic head_free = !v0_r || pop;
  assign in_ready = !v1_r;
  assign out_valid = v0_r;
  assign out_data = d0_r;

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      v0_r <= 1'b0;
      v1_r <= 1'b0;
      d0_r <= '0;
      d1_r <= '0;
    end else if (en) begin
      if (head_free) begin
        v0_r <= v1_r || push;
        d0_r <= v1_r ? d1_r : in_data;
      end
      if (v1_r) begin
        v1_r <= !pop;
      end else begin
        v1_r <= push && v0_r && !pop;
        d1_r <= in_data;
      end
    end
  end

  no_overrun_a: assert property (@(posedge sys_clk) disable iff (rst || !en)
    v0_r && !out_ready |=> v0_r && d0_r == $past(d0_r))
    else $error("held word changed under stall");
endmodule : rtw_skid_buf
`default_nettype wire

// File: rtl/rtw_transceive.sv
// reader transceive controller with guard patterns, shaping timers, fifo and status
`timescale 1ns/1ps
`default_nettype none
module rtw_transceive #(
  parameter int FIFO_DEPTH = 512,
  parameter int AW = 9
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic irq,
  output logic osc_enable,
  input wire logic osc_stable,
  output logic field_on,
  output logic rx_on,
  output logic [7:0] tx_data,
  output logic tx_valid,
  input wire logic tx_ready,
  input wire logic mod_in,
  output logic mod_out,
  output logic [1:0] tx_drive,
  output logic sink_switch,
  input wire logic rx_valid,
  input wire logic [7:0] rx_data,
  input wire logic rx_end,
  input wire logic rx_err,
  input wire logic rx_coll
);
  rtw_pkg::rtw_state_t state_r;
  rtw_pkg::rtw_state_t state_nxt;
  logic [7:0] op_r, tx_wl_r, rx_wl_r, txb1_r, txb2_r;
  logic [7:0] aux_mod_r, ws_cfg_r, ws_cfg2_r, sink_fall_r, sink_rise_r;
  logic [7:0] ov_hi_r, ov_lo_r, un_hi_r, un_lo_r;
  logic [7:0] irq_stat_r, irq_stat_nxt, reg_rdata_r;
  logic irq_r, osc_seen_r, mod_prev_r, mod_out_r, sink_sw_r, rx_on_r;
  logic [1:0] tx_drive_r;
  logic [7:0] sink_cnt_r;
  logic sink_run_r, sink_goal_r;
  logic [15:0] tx_rem_r;
  logic tx_wl_cond_r, rx_wl_cond_r;
  logic [7:0] fifo_mem [FIFO_DEPTH];
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] fifo_cnt_r;

  // register decode
  wire logic wr_cmd = reg_wr_en && reg_addr == rtw_pkg::ADDR_CMD;
  wire logic cmd_stop = wr_cmd && reg_wdata == rtw_pkg::CMD_STOP_ALL;
  wire logic cmd_tx = wr_cmd && reg_wdata == rtw_pkg::CMD_TRANSMIT;
  wire logic wr_fifo = reg_wr_en && reg_addr == rtw_pkg::ADDR_FIFO_DATA;
  wire logic rd_fifo = reg_rd_en && reg_addr == rtw_pkg::ADDR_FIFO_DATA;
  wire logic rd_irq = reg_rd_en && reg_addr == rtw_pkg::ADDR_IRQ_MAIN;
  wire logic op_en = op_r[rtw_pkg::OP_EN_BIT];
  wire logic op_rx_en = op_r[rtw_pkg::OP_RX_EN_BIT];
  wire logic op_tx_en = op_r[rtw_pkg::OP_TX_EN_BIT];
  wire logic ws_en = ws_cfg_r[rtw_pkg::WS_EN_BIT];

  // fifo control; host access is refused while the link side owns that end
  wire logic fifo_full = fifo_cnt_r == (AW+1)'(FIFO_DEPTH);
  wire logic fifo_empty = fifo_cnt_r == '0;
  wire logic [7:0] fifo_head = fifo_mem[rd_ptr_r];
  wire logic buf_in_ready;
  wire logic feed = state_r == rtw_pkg::ST_TX && tx_rem_r != 16'h0 && !fifo_empty
    && buf_in_ready;
  wire logic rx_push = state_r == rtw_pkg::ST_RX && rx_valid;
  wire logic host_push = wr_fifo && state_r != rtw_pkg::ST_RX;
  wire logic push = (rx_push || host_push) && !fifo_full;
  wire logic pop = feed || (rd_fifo && state_r != rtw_pkg::ST_TX && !fifo_empty);
  wire logic [7:0] push_data = rx_push ? rx_data : reg_wdata;
  wire logic [AW:0] cnt_nxt = fifo_cnt_r + (AW+1)'(push) - (AW+1)'(pop);
  wire logic rx_overflow = rx_push && fifo_full;

  // transceive sequencing
  wire logic tx_last = state_r == rtw_pkg::ST_TX && tx_rem_r == 16'h0 && !tx_valid;
  wire logic rx_done = state_r == rtw_pkg::ST_RX && rx_end;
  wire logic tx_wl_cond = state_r == rtw_pkg::ST_TX && tx_rem_r > 16'(fifo_cnt_r)
    && fifo_cnt_r < (AW+1)'(tx_wl_r);
  wire logic rx_wl_cond = state_r == rtw_pkg::ST_RX
    && fifo_cnt_r > (AW+1)'(rx_wl_r);
  assign state_nxt = cmd_stop ? rtw_pkg::ST_IDLE :
    (cmd_tx && op_tx_en) ? rtw_pkg::ST_TX :
    tx_last ? rtw_pkg::ST_RX :
    rx_done ? rtw_pkg::ST_IDLE : state_r;

  // interrupt status: a set in the reading cycle survives the clear
  wire logic [7:0] irq_set = {
    osc_stable && !osc_seen_r && op_en,
    (tx_wl_cond && !tx_wl_cond_r) || (rx_wl_cond && !rx_wl_cond_r),
    1'b0,
    rx_done,
    tx_last,
    state_r == rtw_pkg::ST_RX && rx_coll,
    (state_r == rtw_pkg::ST_RX && rx_err) || rx_overflow,
    1'b0};
  assign irq_stat_nxt = (rd_irq ? 8'h00 : irq_stat_r) | irq_set;

  // read selection
  wire logic [7:0] rd_mux =
    reg_addr == rtw_pkg::ADDR_OP_CTRL ? op_r :
    reg_addr == rtw_pkg::ADDR_TX_WL ? tx_wl_r :
    reg_addr == rtw_pkg::ADDR_RX_WL ? rx_wl_r :
    reg_addr == rtw_pkg::ADDR_IRQ_MAIN ? irq_stat_r :
    reg_addr == rtw_pkg::ADDR_FIFO_STAT1 ? fifo_cnt_r[7:0] :
    reg_addr == rtw_pkg::ADDR_FIFO_STAT2 ? 8'(fifo_cnt_r[AW:8]) :
    reg_addr == rtw_pkg::ADDR_TXB1 ? txb1_r :
    reg_addr == rtw_pkg::ADDR_TXB2 ? txb2_r :
    reg_addr == rtw_pkg::ADDR_AUX_MOD ? aux_mod_r :
    reg_addr == rtw_pkg::ADDR_WS_CFG ? ws_cfg_r :
    reg_addr == rtw_pkg::ADDR_WS_CFG2 ? ws_cfg2_r :
    reg_addr == rtw_pkg::ADDR_OV_HI ? ov_hi_r :
    reg_addr == rtw_pkg::ADDR_OV_LO ? ov_lo_r :
    reg_addr == rtw_pkg::ADDR_UN_HI ? un_hi_r :
    reg_addr == rtw_pkg::ADDR_UN_LO ? un_lo_r :
    reg_addr == rtw_pkg::ADDR_SINK_FALL ? sink_fall_r :
    reg_addr == rtw_pkg::ADDR_SINK_RISE ? sink_rise_r :
    reg_addr == rtw_pkg::ADDR_FIFO_DATA ? fifo_head : 8'h00;

  // modulation edges: mod_in high means carrier modulated
  wire logic mod_fall_start = mod_in && !mod_prev_r;
  wire logic mod_rise_end = !mod_in && mod_prev_r;
  wire logic any_edge = mod_fall_start || mod_rise_end;
  wire rtw_pkg::rtw_guard_cfg_t ov_cfg = {ov_hi_r, ov_lo_r};
  wire rtw_pkg::rtw_guard_cfg_t un_cfg = {un_hi_r, un_lo_r};
  wire logic ov_act, un_act;
  wire logic [1:0] ov_drive, un_drive;
  wire logic [1:0] drive_mux = un_act ? un_drive : ov_act ? ov_drive : rtw_pkg::DRV_NORMAL;
  wire logic [7:0] sink_load = mod_fall_start ? sink_fall_r : sink_rise_r;

  // overshoot follows the end of modulation
  rtw_guard_seq u_over (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .start(mod_rise_end),
    .abort(any_edge),
    .cfg(ov_cfg),
    .active(ov_act),
    .drive(ov_drive)
  );

  // undershoot follows the start of modulation
  rtw_guard_seq u_under (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .start(mod_fall_start),
    .abort(any_edge),
    .cfg(un_cfg),
    .active(un_act),
    .drive(un_drive)
  );

  // the buffer absorbs a stalled modulator without losing a fifo word
  rtw_skid_buf #(.W(8)) u_txbuf (
    .sys_clk(sys_clk),
    .rst(rst),
    .en(clk_en),
    .in_valid(feed),
    .in_ready(buf_in_ready),
    .in_data(fifo_head),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      op_r <= rtw_pkg::REG_RESET;
      tx_wl_r <= rtw_pkg::TX_WL_RESET;
      rx_wl_r <= rtw_pkg::RX_WL_RESET;
      txb1_r <= rtw_pkg::REG_RESET;
      txb2_r <= rtw_pkg::REG_RESET;
      aux_mod_r <= rtw_pkg::REG_RESET;
      ws_cfg_r <= rtw_pkg::REG_RESET;
      ws_cfg2_r <= rtw_pkg::REG_RESET;
      ov_hi_r <= rtw_pkg::REG_RESET;
      ov_lo_r <= rtw_pkg::REG_RESET;
      un_hi_r <= rtw_pkg::REG_RESET;
      un_lo_r <= rtw_pkg::REG_RESET;
      sink_fall_r <= rtw_pkg::REG_RESET;
      sink_rise_r <= rtw_pkg::REG_RESET;
    end else if (clk_en && reg_wr_en) begin
      unique case (reg_addr)
        rtw_pkg::ADDR_OP_CTRL: op_r <= reg_wdata;
        rtw_pkg::ADDR_TX_WL: tx_wl_r <= reg_wdata;
        rtw_pkg::ADDR_RX_WL: rx_wl_r <= reg_wdata;
        rtw_pkg::ADDR_TXB1: txb1_r <= reg_wdata;
        rtw_pkg::ADDR_TXB2: txb2_r <= reg_wdata;
        rtw_pkg::ADDR_AUX_MOD: aux_mod_r <= reg_wdata;
        rtw_pkg::ADDR_WS_CFG: ws_cfg_r <= reg_wdata;
        rtw_pkg::ADDR_WS_CFG2: ws_cfg2_r <= reg_wdata;
        rtw_pkg::ADDR_OV_HI: ov_hi_r <= reg_wdata;
        rtw_pkg::ADDR_OV_LO: ov_lo_r <= reg_wdata;
        rtw_pkg::ADDR_UN_HI: un_hi_r <= reg_wdata;
        rtw_pkg::ADDR_UN_LO: un_lo_r <= reg_wdata;
        rtw_pkg::ADDR_SINK_FALL: sink_fall_r <= reg_wdata;
        rtw_pkg::ADDR_SINK_RISE: sink_rise_r <= reg_wdata;
        default: ;
      endcase
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_r <= rtw_pkg::ST_IDLE;
      tx_rem_r <= 16'h0;
      rx_on_r <= 1'b0;
      irq_stat_r <= 8'h00;
      irq_r <= 1'b0;
      osc_seen_r <= 1'b0;
      tx_wl_cond_r <= 1'b0;
      rx_wl_cond_r <= 1'b0;
      reg_rdata_r <= 8'h00;
    end else if (clk_en) begin
      state_r <= state_nxt;
      if (cmd_tx && op_tx_en) begin
        tx_rem_r <= {txb1_r, txb2_r};
      end else if (feed) begin
        tx_rem_r <= tx_rem_r - 16'h1;
      end else if (cmd_stop) begin
        tx_rem_r <= 16'h0;
      end
      // receiver watches the field only between transmit end and receive end
      rx_on_r <= state_nxt == rtw_pkg::ST_RX && op_rx_en;
      irq_stat_r <= irq_stat_nxt;
      irq_r <= |irq_stat_nxt;
      osc_seen_r <= osc_stable && op_en;
      tx_wl_cond_r <= tx_wl_cond;
      rx_wl_cond_r <= rx_wl_cond;
      if (reg_rd_en) begin
        reg_rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      fifo_cnt_r <= '0;
    end else if (clk_en) begin
      if (cmd_stop) begin
        wr_ptr_r <= '0;
        rd_ptr_r <= '0;
        fifo_cnt_r <= '0;
      end else begin
        if (push) begin
          wr_ptr_r <= wr_ptr_r + AW'(1);
        end
        if (pop) begin
          rd_ptr_r <= rd_ptr_r + AW'(1);
        end
        fifo_cnt_r <= cnt_nxt;
      end
    end
  end

  // storage has no reset so it can map to ram
  always_ff @(posedge sys_clk) begin
    if (clk_en && push) begin
      fifo_mem[wr_ptr_r] <= push_data;
    end
  end

  // sink switch: fall timer from modulation start, rise timer from its end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      mod_prev_r <= 1'b0;
      mod_out_r <= 1'b0;
      tx_drive_r <= rtw_pkg::DRV_NORMAL;
      sink_cnt_r <= 8'h00;
      sink_run_r <= 1'b0;
      sink_goal_r <= 1'b0;
      sink_sw_r <= 1'b0;
    end else if (clk_en) begin
      mod_prev_r <= mod_in;
      mod_out_r <= mod_in;
      // guard drive lags mod_out by one cycle, so bit 0 lands on cycle one
      tx_drive_r <= drive_mux;
      if (any_edge && ws_en) begin
        sink_cnt_r <= sink_load;
        sink_run_r <= 1'b1;
        sink_goal_r <= mod_fall_start;
      end else if (sink_run_r && sink_cnt_r != 8'h00) begin
        sink_cnt_r <= sink_cnt_r - 8'h01;
      end else if (sink_run_r) begin
        sink_run_r <= 1'b0;
        sink_sw_r <= sink_goal_r;
      end
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign irq = irq_r;
  assign osc_enable = op_en;
  assign field_on = op_tx_en;
  assign rx_on = rx_on_r;
  assign mod_out = mod_out_r;
  assign tx_drive = tx_drive_r;
  assign sink_switch = sink_sw_r;

  osc_flag_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    op_en && osc_stable && !osc_seen_r |=> irq_stat_r[rtw_pkg::IRQ_OSC] && irq_r)
    else $error("oscillator stable flag not raised");
  tx_end_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    tx_last && !cmd_stop |=> irq_stat_r[rtw_pkg::IRQ_TXE] && state_r == rtw_pkg::ST_RX)
    else $error("transmit end not flagged");
  rx_start_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    tx_last && !cmd_stop |=> rx_on_r == $past(op_rx_en))
    else $error("receiver not started after transmit");
  rx_end_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    rx_done && !cmd_stop |=> irq_stat_r[rtw_pkg::IRQ_RXE] && state_r == rtw_pkg::ST_IDLE
    && !rx_on_r)
    else $error("receive end not flagged");
  rx_error_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    state_r == rtw_pkg::ST_RX && rx_coll |=> irq_stat_r[rtw_pkg::IRQ_COL])
    else $error("collision flag missing");
  water_level_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    rx_wl_cond && !rx_wl_cond_r |=> irq_stat_r[rtw_pkg::IRQ_WL])
    else $error("receive water level flag missing");
  read_clear_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    rd_irq && irq_set == 8'h00 |=> irq_stat_r == 8'h00 && !irq_r)
    else $error("status not cleared by read");
  sink_timer_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en)
    ws_en && mod_fall_start |=> sink_run_r && sink_goal_r
    && sink_cnt_r == $past(sink_fall_r))
    else $error("fall timer not started at modulation start");
  transceive_c: cover property (@(posedge sys_clk) disable iff (rst || !clk_en)
    tx_last ##[1:200] rx_done);
  tx_refill_c: cover property (@(posedge sys_clk) disable iff (rst || !clk_en)
    tx_wl_cond && !tx_wl_cond_r);
  stall_c: cover property (@(posedge sys_clk) disable iff (rst || !clk_en)
    tx_valid && !tx_ready && !buf_in_ready);
endmodule : rtw_transceive
`default_nettype wire

// File: testbench/rtw_tag_model.sv
// behavioural transponder: stalls every other cycle, answers two bytes with faults
`timescale 1ns/1ps
`default_nettype none
module rtw_tag_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic rx_on,
  output logic tx_ready,
  output logic rx_valid,
  output logic [7:0] rx_data,
  output logic rx_end,
  output logic rx_err,
  output logic rx_coll
);
  logic [7:0] cnt_r;
  // ready alternates so every other cycle is stalled; a byte offered while ready is high goes without a stall
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      tx_ready <= 1'b0;
      cnt_r <= 8'h00;
    end else begin
      tx_ready <= ~tx_ready;
      cnt_r <= rx_on ? cnt_r + 8'h01 : 8'h00;
    end
  end
  assign rx_valid = rx_on && (cnt_r == 8'h03 || cnt_r == 8'h05);
  // idle data is never the last byte, so a stale sample shows
  assign rx_data = cnt_r == 8'h03 ? 8'hA5 : cnt_r == 8'h05 ? 8'h5A : ~cnt_r;
  assign rx_err = rx_on && cnt_r == 8'h0A;
  assign rx_coll = rx_on && cnt_r == 8'h0A;
  assign rx_end = rx_on && cnt_r == 8'h0C;
endmodule : rtw_tag_model
`default_nettype wire

// File: testbench/testbench.sv
// self-checking bench of the reader transceive block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] e;} rtw_row_t;
  logic sys_clk = 0, rst = 1, clk_en = 1, wr = 0, rd = 0, osc_stable = 0, mod_in = 0;
  logic [7:0] addr = 0, wdata = 0, rdata, tx_data, rx_data, d;
  logic irq, osc_enable, field_on, rx_on, tx_valid, tx_ready, mod_out, sink_switch;
  logic rx_valid, rx_end, rx_err, rx_coll;
  logic [1:0] tx_drive;
  logic [7:0] sent_q[$];
  int n_errors = 0, checks = 0, cycles = 0;
  rtw_row_t rows[7] = '{{1'b0, 8'h03, 8'h00, 8'h10}, {1'b0, 8'h04, 8'h00, 8'h40},
    {1'b1, 8'h2F, 8'h28, 8'h28},
    {1'b1, 8'h28, 8'h94, 8'h94}, {1'b1, 8'h2E, 8'h08, 8'h08},
    {1'b1, 8'h34, 8'h9C, 8'h9C}, {1'b1, 8'h77, 8'h5A, 8'h00}};
  logic [15:0] gcfg[4] = '{16'h7003, 16'h92A5, 16'h4000, 16'h0081};
  rtw_transceive dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .reg_wr_en(wr),
    .reg_rd_en(rd), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata), .irq(irq),
    .osc_enable(osc_enable), .osc_stable(osc_stable), .field_on(field_on), .rx_on(rx_on),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .mod_in(mod_in),
    .mod_out(mod_out), .tx_drive(tx_drive), .sink_switch(sink_switch), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err), .rx_coll(rx_coll));
  rtw_tag_model tag (.sys_clk(sys_clk), .rst(rst), .rx_on(rx_on), .tx_ready(tx_ready),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_end(rx_end), .rx_err(rx_err),
    .rx_coll(rx_coll));
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    if (tx_valid && tx_ready) sent_q.push_back(tx_data);
    cycles++;
    if (cycles == 5000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic wreg(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    wr = 1;
    addr = a;
    wdata = v;
    @(negedge sys_clk);
    wr = 0;
  endtask : wreg
  task automatic rreg(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    rd = 1;
    addr = a;
    @(negedge sys_clk);
    rd = 0;
    v = rdata;
  endtask : rreg
  // cfg is {selector, pattern}; mod_out moves on the first edge, bit n shows n+1 edges later
  task automatic guard(input logic lvl, input logic [15:0] cfg);
    logic [1:0] exp_drv;
    wreg(lvl ? rtw_pkg::ADDR_UN_HI : rtw_pkg::ADDR_OV_HI, cfg[15:8]);
    wreg(lvl ? rtw_pkg::ADDR_UN_LO : rtw_pkg::ADDR_OV_LO, cfg[7:0]);
    @(negedge sys_clk);
    mod_in = lvl;
    repeat (2) @(posedge sys_clk);
    for (int n = 0; n < 16; n++) begin
      @(negedge sys_clk);
      exp_drv = (n < 14 && cfg[n]) ? cfg[15:14] : rtw_pkg::DRV_NORMAL;
      check(tx_drive, exp_drv);
    end
    check(mod_out, lvl);
  endtask : guard
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : report_and_stop
  initial begin
    repeat (4) @(negedge sys_clk);
    rst = 0;
    check({irq, tx_drive, tx_valid, rx_on}, 5'b01100);
    foreach (rows[i]) begin
      if (rows[i].w) wreg(rows[i].a, rows[i].d);
      rreg(rows[i].a, d);
      check(d, rows[i].e);
    end
    foreach (gcfg[i]) guard(i % 2 == 0, gcfg[i]);
    // short timers so the clamp visibly follows both edges
    wreg(rtw_pkg::ADDR_SINK_FALL, 8'h04);
    wreg(rtw_pkg::ADDR_SINK_RISE, 8'h02);
    @(negedge sys_clk);
    mod_in = 1;
    repeat (2) @(negedge sys_clk);
    check(sink_switch, 1'b0);
    repeat (6) @(negedge sys_clk);
    check(sink_switch, 1'b1);
    mod_in = 0;
    repeat (8) @(negedge sys_clk);
    check(sink_switch, 1'b0);
    wreg(rtw_pkg::ADDR_OP_CTRL, 8'hC8);
    check({osc_enable, field_on}, 2'b11);
    osc_stable = 1;
    repeat (4) @(negedge sys_clk);
    check(irq, 1'b1);
    rreg(rtw_pkg::ADDR_IRQ_MAIN, d);
    check(d, 8'h80);
    rreg(rtw_pkg::ADDR_IRQ_MAIN, d);
    check(d, 8'h00);
    wreg(rtw_pkg::ADDR_WS_CFG2, 8'h1C);
    rreg(rtw_pkg::ADDR_WS_CFG2, d);
    check(d, 8'h1C);
    wreg(rtw_pkg::ADDR_CMD, rtw_pkg::CMD_STOP_ALL);
    wreg(rtw_pkg::ADDR_TX_WL, 8'h02);
    wreg(rtw_pkg::ADDR_TXB1, 8'h00);
    wreg(rtw_pkg::ADDR_TXB2, 8'h04);
    wreg(rtw_pkg::ADDR_FIFO_DATA, 8'h3C);
    wreg(rtw_pkg::ADDR_FIFO_DATA, 8'hC3);
    wreg(rtw_pkg::ADDR_FIFO_DATA, 8'h81);
    wreg(rtw_pkg::ADDR_CMD, rtw_pkg::CMD_TRANSMIT);
    // four bytes announced, three loaded: the water level must call for the last
    for (int k = 0; k < 100 && irq !== 1'b1; k++) @(negedge sys_clk);
    rreg(rtw_pkg::ADDR_IRQ_MAIN, d);
    check(d, 8'h40);
    wreg(rtw_pkg::ADDR_FIFO_DATA, 8'h7E);
    for (int k = 0; k < 100 && irq !== 1'b1; k++) @(negedge sys_clk);
    rreg(rtw_pkg::ADDR_IRQ_MAIN, d);
    check(d, 8'h08);
    check(sent_q.size(), 4);
    check({sent_q[0], sent_q[1], sent_q[2], sent_q[3]}, 32'h3CC3817E);
    repeat (20) @(negedge sys_clk);
    check(rx_on, 1'b0);
    rreg(rtw_pkg::ADDR_IRQ_MAIN, d);
    check(d, 8'h16);
    rreg(rtw_pkg::ADDR_FIFO_STAT1, d);
    check(d, 8'h02);
    rreg(rtw_pkg::ADDR_FIFO_DATA, d);
    check(d, 8'hA5);
    rreg(rtw_pkg::ADDR_FIFO_DATA, d);
    check(d, 8'h5A);
    report_and_stop();
  end
endmodule : testbench
`default_nettype wire
